// >>> cpu_standby_halt_stop_control_tb.sv
// self-checking bench joining processor and external ends
`timescale 1ns/1ps
`include "stby_consts.svh"
module cpu_standby_halt_stop_control_tb;
    logic clk = 1'b0, rst_n = 1'b0, halt_exec = 1'b0, ie = 1'b0, return_from_interrupt = 1'b0;
    logic stop_rq = 1'b0, wake = 1'b0, irq = 1'b0, nmi = 1'b0, hold = 1'b0;
    logic [7:0] vector = 8'h00;
    logic [15:0] addr = 16'h0000;
    logic halted, clk_en, svc_start, svc_nmi, resume, stopped, grant;
    logic [7:0] svc_vec;
    logic [15:0] addr_out, a;
    int miscompares = 0, samples_checked = 0, n;
    stby_if stby_if_i ();
    stby_cpu stby_cpu_i (.CLK_I(clk), .RST_N_I(rst_n), .LINK(stby_if_i.cpu), .HALT_EXEC_I(halt_exec),
        .IRQ_ENABLE_FLAG_I(ie), .RETURN_FROM_INTERRUPT_I(return_from_interrupt), .ADDR_I(addr), .HALTED_O(halted),
        .CORE_CLK_EN_O(clk_en), .SVC_START_O(svc_start), .SVC_NMI_O(svc_nmi), .SVC_VECTOR_O(svc_vec),
        .RESUME_AFTER_HALT_O(resume), .ADDR_O(addr_out));
    stby_ext stby_ext_i (.CLK_I(clk), .RST_N_I(rst_n), .LINK(stby_if_i.ext), .STOP_REQ_I(stop_rq),
        .WAKE_REQ_I(wake), .IRQ_I(irq), .NMI_I(nmi), .HOLD_I(hold), .VECTOR_I(vector), .STOPPED_O(stopped),
        .HOLD_GRANT_O(grant));
    stby_link_chk stby_link_chk_i (.clk(clk), .rst_n(rst_n), .clk_run(stby_if_i.clk_run),
        .irq_req(stby_if_i.irq_req), .nmi_req(stby_if_i.nmi_req), .bus_hold_request(stby_if_i.bus_hold_request),
        .bus_hold_grant(stby_if_i.bus_hold_grant), .halt_ack_cycle(stby_if_i.halt_ack_cycle),
        .irq_acknowledge_cycle(stby_if_i.irq_acknowledge_cycle), .halted(stby_if_i.halted),
        .ctrl_out(stby_if_i.ctrl_out));
    // ====================
    // shared tasks
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic halt_cpu();
        halt_exec = 1'b1;
        tick(1);
        halt_exec = 1'b0;
        for (n = 0; n < 8 && halted !== 1'b1; n++) tick(1);
        chk("halted", 16'h1, halted);
        chk("halt ack", 16'h1, stby_if_i.halt_ack_cycle);
    endtask : halt_cpu
    // ====================
    // scenarios
    task automatic t_hold_nmi();
        halt_cpu();
        hold = 1'b1;
        tick(3);
        chk("grant", 16'h1, grant);
        chk("core clock", 16'h0, clk_en);
        hold = 1'b0;
        tick(3);
        chk("rehalt", 16'h1, halted);
        nmi = 1'b1;
        for (n = 0; n < 8 && svc_nmi !== 1'b1; n++) tick(1);
        nmi = 1'b0;
        chk("nmi entry", 16'h1, svc_nmi);
        chk("nmi vector", `STBY_NMI_VEC, svc_vec);
        tick(1);
        return_from_interrupt = 1'b1;
        tick(1);
        return_from_interrupt = 1'b0;
        chk("nmi return", 16'h1, resume);
        $display("test hold and nmi done");
    endtask : t_hold_nmi
    task automatic t_irq(input logic en);
        ie = en;
        vector = 8'h5a;
        tick(4);
        halt_cpu();
        irq = 1'b1;
        for (n = 0; n < 8 && stby_if_i.irq_acknowledge_cycle !== 1'b1 && resume !== 1'b1; n++) tick(1);
        irq = 1'b0;
        chk("ack cycle", {15'h0, en}, stby_if_i.irq_acknowledge_cycle);
        if (en) begin
            tick(1);
            chk("service", 16'h1, svc_start);
            chk("vector", 16'h5a, svc_vec);
            chk("irq not nmi", 16'h0, svc_nmi);
            tick(1);
            return_from_interrupt = 1'b1;
            tick(1);
            return_from_interrupt = 1'b0;
            for (n = 0; n < 8 && resume !== 1'b1; n++) tick(1);
        end
        chk("resume", 16'h1, resume);
        $display("test irq done");
    endtask : t_irq
    task automatic t_stop();
        tick(4);
        stop_rq = 1'b1;
        tick(1);
        stop_rq = 1'b0;
        tick(12);
        halt_cpu();
        a = addr_out;
        addr = 16'hbeef;
        for (n = 0; n < 60 && stopped !== 1'b1; n++) tick(1);
        chk("clock gate", 16'h0, stby_if_i.clk_run);
        irq = 1'b1;
        tick(5);
        irq = 1'b0;
        chk("halted in stop", 16'h1, halted);
        chk("address held", a, addr_out);
        wake = 1'b1;
        for (n = 0; n < 30 && stopped !== 1'b0; n++) tick(1);
        wake = 1'b0;
        tick(12);
        chk("halt after stop", 16'h1, halted);
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        tick(1);
        chk("reset exit", 16'h0, halted);
        chk("core clock run", 16'h1, clk_en);
        chk("control run", 16'h1, stby_if_i.ctrl_out);
        $display("test stop done");
    endtask : t_stop
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up
    // clock, watchdog and main sequence
    initial begin
        forever #10 clk = ~clk;
    end
    initial begin
        #100000;
        miscompares++;
        wrap_up();
    end
    initial begin
        tick(8);
        rst_n = 1'b1;
        t_hold_nmi();
        t_irq(1'b1);
        t_irq(1'b0);
        t_stop();
        wrap_up();
    end
endmodule : cpu_standby_halt_stop_control_tb

// >>> stby_consts.svh
// timing, width, vector and reset address constants for the standby controller
`ifndef STBY_CONSTS_SVH
`define STBY_CONSTS_SVH
`define STBY_CLK_HZ 50000000
`define STBY_GUARD_CLKS 10
`define STBY_GUARD_W 4
`define STBY_VEC_W 8
`define STBY_NMI_VEC 8'h02
`define STBY_ADDR_RST 16'h0000
`endif

// >>> stby_cpu.sv
// processor end: halt entry, wake-up, hold service and output states
`timescale 1ns/1ps
`include "stby_consts.svh"
module stby_cpu (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    stby_if.cpu LINK,
    input wire logic HALT_EXEC_I,
    input wire logic IRQ_ENABLE_FLAG_I,
    input wire logic RETURN_FROM_INTERRUPT_I,
    input wire logic [15:0] ADDR_I,
    output logic HALTED_O,
    output logic CORE_CLK_EN_O,
    output logic SVC_START_O,
    output logic SVC_NMI_O,
    output logic [7:0] SVC_VECTOR_O,
    output logic RESUME_AFTER_HALT_O,
    output logic [15:0] ADDR_O
);
    // ==========================================
    // decode functions

    // the two states in which the core sleeps and the bus rests
    function automatic logic standby_state(input stby_pkg::stby_cpu_state_t s);
        return (s == stby_pkg::STBY_HALT) || (s == stby_pkg::STBY_HOLD);
    endfunction : standby_state

    // the states in which the processor drives its bus control strobes
    function automatic logic bus_active_state(input stby_pkg::stby_cpu_state_t s);
        return (s == stby_pkg::STBY_RUN) || (s == stby_pkg::STBY_ACK);
    endfunction : bus_active_state

    // ==========================================
    // state and output registers

    // sequencer state
    stby_pkg::stby_cpu_state_t state_reg, state_next;
    // service vector handed to the core
    logic [7:0] vec_reg, vec_next;
    // address bus value, frozen while the core sleeps
    logic [15:0] addr_reg, addr_next;
    // aggregate control strobe
    logic ctrl_reg, ctrl_next;
    // one-cycle pulses towards the core and the bus
    logic svc_reg, svc_next;
    logic svc_nmi_reg, svc_nmi_next;
    logic resume_reg, resume_next;
    logic halt_ack_reg, halt_ack_next;
    // set while a service routine entered from standby is running
    logic in_svc_reg, in_svc_next;

    // ==========================================
    // decode

    // named decodes of the current state and the request inputs
    wire clk_ok;
    wire is_run;
    wire is_halt;
    wire is_ack;
    wire is_svc;
    wire irq_take;
    wire wake;
    wire nmi_wake;
    wire plain_wake;
    wire enter_halt;
    wire enter_svc;
    wire enter_run;

    // a stopped clock gives no enabled edge, so every flop keeps its value
    assign clk_ok = LINK.clk_run;
    assign is_run = (state_reg == stby_pkg::STBY_RUN);
    assign is_halt = (state_reg == stby_pkg::STBY_HALT);
    assign is_ack = (state_reg == stby_pkg::STBY_ACK);
    assign is_svc = (state_reg == stby_pkg::STBY_SVC);

    // wake-up sources, in priority order nmi, enabled irq, disabled irq
    assign irq_take = LINK.irq_req && IRQ_ENABLE_FLAG_I;
    assign wake = LINK.nmi_req || LINK.irq_req;
    assign nmi_wake = is_halt && LINK.nmi_req;
    assign plain_wake = is_halt && wake && !LINK.nmi_req && !irq_take;

    // transitions that the output registers follow
    assign enter_halt = is_run && HALT_EXEC_I;
    assign enter_svc = (state_next == stby_pkg::STBY_SVC);
    assign enter_run = (state_next == stby_pkg::STBY_RUN);

    // ==========================================
    // next state

    // halt only by instruction; nmi beats irq beats hold
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            stby_pkg::STBY_RUN: begin
                if (enter_halt) state_next = stby_pkg::STBY_HALT;
            end
            stby_pkg::STBY_HALT: begin
                if (LINK.nmi_req) state_next = stby_pkg::STBY_SVC;
                else if (irq_take) state_next = stby_pkg::STBY_ACK;
                else if (wake) state_next = stby_pkg::STBY_RUN;
                else if (LINK.bus_hold_request) state_next = stby_pkg::STBY_HOLD;
            end
            stby_pkg::STBY_HOLD: begin
                if (!LINK.bus_hold_request) state_next = stby_pkg::STBY_HALT;
            end
            stby_pkg::STBY_ACK: state_next = stby_pkg::STBY_SVC;
            stby_pkg::STBY_SVC: state_next = stby_pkg::STBY_RUN;
            default: state_next = stby_pkg::STBY_RUN;
        endcase
    end

    // ==========================================
    // next register values

    // pulses: service entry, nmi entry, return after halt, halt acknowledge
    assign svc_next = enter_svc;
    assign svc_nmi_next = enter_svc && is_halt;
    assign resume_next = plain_wake || (in_svc_reg && RETURN_FROM_INTERRUPT_I);
    assign halt_ack_next = enter_halt;

    // vector from the acknowledge cycle, fixed vector for nmi
    assign vec_next = is_ack ? LINK.irq_vector : (nmi_wake ? `STBY_NMI_VEC : vec_reg);

    // the service state sets the flag and wins over a return in the same cycle
    assign in_svc_next = is_svc ? 1'b1 : (RETURN_FROM_INTERRUPT_I ? 1'b0 : in_svc_reg);

    // the address follows the core only while it runs; control strobes drop in standby
    assign addr_next = enter_run ? ADDR_I : addr_reg;
    assign ctrl_next = bus_active_state(state_next);

    // ==========================================
    // registers

    // sequencer state; reset abandons standby and restarts normally
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_reg <= stby_pkg::STBY_RUN;
        end else if (clk_ok) begin
            state_reg <= state_next;
        end
    end

    // one-cycle pulses
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            svc_reg <= 1'b0;
            svc_nmi_reg <= 1'b0;
            resume_reg <= 1'b0;
            halt_ack_reg <= 1'b0;
        end else if (clk_ok) begin
            svc_reg <= svc_next;
            svc_nmi_reg <= svc_nmi_next;
            resume_reg <= resume_next;
            halt_ack_reg <= halt_ack_next;
        end
    end

    // service vector and service flag
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            vec_reg <= 8'h00;
            in_svc_reg <= 1'b0;
        end else if (clk_ok) begin
            vec_reg <= vec_next;
            in_svc_reg <= in_svc_next;
        end
    end

    // bus outputs
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            addr_reg <= `STBY_ADDR_RST;
            ctrl_reg <= 1'b0;
        end else if (clk_ok) begin
            addr_reg <= addr_next;
            ctrl_reg <= ctrl_next;
        end
    end

    // ==========================================
    // outputs to the core

    // the core clock stops in standby and while the input clock is held
    assign HALTED_O = standby_state(state_reg);
    assign CORE_CLK_EN_O = clk_ok && !HALTED_O;
    assign SVC_START_O = svc_reg;
    assign SVC_NMI_O = svc_nmi_reg;
    assign SVC_VECTOR_O = vec_reg;
    assign RESUME_AFTER_HALT_O = resume_reg;
    assign ADDR_O = addr_reg;

    // ==========================================
    // outputs on the link

    // grant only from the hold state; halt acknowledge is its own flop, not a control strobe
    assign LINK.bus_hold_grant = (state_reg == stby_pkg::STBY_HOLD);
    assign LINK.halt_ack_cycle = halt_ack_reg;
    assign LINK.irq_acknowledge_cycle = is_ack;
    assign LINK.halted = HALTED_O;
    assign LINK.ctrl_out = ctrl_reg;
endmodule : stby_cpu

// >>> stby_ext.sv
// external end: gates requests and stops/restarts the processor clock
`timescale 1ns/1ps
`include "stby_consts.svh"
module stby_ext #(
    parameter int GUARD = `STBY_GUARD_CLKS
) (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    stby_if.ext LINK,
    input wire logic STOP_REQ_I,
    input wire logic WAKE_REQ_I,
    input wire logic IRQ_I,
    input wire logic NMI_I,
    input wire logic HOLD_I,
    input wire logic [7:0] VECTOR_I,
    output logic STOPPED_O,
    output logic HOLD_GRANT_O
);
    // ==========================================
    // state and guard counter
    stby_pkg::stby_ext_state_t state_reg, state_next;
    logic [`STBY_GUARD_W-1:0] cnt_reg, cnt_next;
    wire cnt_done = (cnt_reg == `STBY_GUARD_W'(GUARD - 1));
    wire gate_req = (state_reg == stby_pkg::STBY_X_IDLE);

    always_comb begin
        state_next = state_reg;
        cnt_next = 4'h0;
        unique case (state_reg)
            stby_pkg::STBY_X_IDLE: if (STOP_REQ_I) state_next = stby_pkg::STBY_X_PRE;
            stby_pkg::STBY_X_PRE: begin
                cnt_next = cnt_done ? cnt_reg : cnt_reg + 4'h1;
                if (cnt_done && LINK.halt_ack_cycle) state_next = stby_pkg::STBY_X_WAIT;
            end
            stby_pkg::STBY_X_WAIT: begin
                cnt_next = cnt_reg + 4'h1;
                if (cnt_done) state_next = stby_pkg::STBY_X_STOP;
            end
            stby_pkg::STBY_X_STOP: if (WAKE_REQ_I) state_next = stby_pkg::STBY_X_POST;
            stby_pkg::STBY_X_POST: begin
                cnt_next = cnt_reg + 4'h1;
                if (cnt_done) state_next = stby_pkg::STBY_X_IDLE;
            end
            default: state_next = stby_pkg::STBY_X_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_reg <= stby_pkg::STBY_X_IDLE;
            cnt_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= (state_next == state_reg) ? cnt_next : 4'h0;
        end
    end

    // ==========================================
    // clock gate changes at a rising edge, modelling a stop in the low phase
    assign LINK.clk_run = (state_reg != stby_pkg::STBY_X_STOP);
    assign LINK.irq_req = IRQ_I && gate_req;
    assign LINK.nmi_req = NMI_I && gate_req;
    assign LINK.bus_hold_request = HOLD_I && gate_req;
    assign LINK.irq_vector = VECTOR_I;
    assign STOPPED_O = !LINK.clk_run;
    assign HOLD_GRANT_O = LINK.bus_hold_grant;
endmodule : stby_ext

// >>> stby_if.sv
// link between the processor standby logic and the external control logic
`timescale 1ns/1ps
interface stby_if;
    logic clk_run;           // external gate: processor clock runs
    logic irq_req;           // maskable interrupt request
    logic nmi_req;           // nonmaskable interrupt request
    logic bus_hold_request;
    logic bus_hold_grant;
    logic halt_ack_cycle;    // one-cycle halt acknowledge bus cycle
    logic irq_acknowledge_cycle;
    logic [7:0] irq_vector;
    logic halted;
    logic ctrl_out;          // aggregate control output strobe
    modport cpu (input clk_run, irq_req, nmi_req, bus_hold_request, irq_vector,
                 output bus_hold_grant, halt_ack_cycle, irq_acknowledge_cycle, halted, ctrl_out);
    modport ext (output clk_run, irq_req, nmi_req, bus_hold_request, irq_vector,
                 input bus_hold_grant, halt_ack_cycle, irq_acknowledge_cycle, halted, ctrl_out);
endinterface : stby_if

// >>> stby_link_chk.sv
// assertions on the standby link between the two ends
`timescale 1ns/1ps
`include "stby_consts.svh"
module stby_link_chk #(parameter int GUARD = `STBY_GUARD_CLKS) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_run,
    input wire logic irq_req,
    input wire logic nmi_req,
    input wire logic bus_hold_request,
    input wire logic bus_hold_grant,
    input wire logic halt_ack_cycle,
    input wire logic irq_acknowledge_cycle,
    input wire logic halted,
    input wire logic ctrl_out
);
    // ====================
    // helper counters
    logic [4:0] ack_age_reg;
    logic [4:0] quiet_age_reg;
    logic [4:0] run_age_reg;
    wire quiet = !irq_req && !nmi_req && !bus_hold_request;
    // saturating ages since halt ack, since the last request and since the clock restarted
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_age_reg <= 5'h00;
            quiet_age_reg <= 5'h00;
            run_age_reg <= 5'h1f;
        end else begin
            ack_age_reg <= halt_ack_cycle ? 5'h00 : ack_age_reg + {4'h0, ack_age_reg != 5'h1f};
            quiet_age_reg <= !quiet ? 5'h00 : quiet_age_reg + {4'h0, quiet_age_reg != 5'h1f};
            run_age_reg <= !clk_run ? 5'h00 : run_age_reg + {4'h0, run_age_reg != 5'h1f};
        end
    end
    // ====================
    // properties
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence quiet_s; quiet; endsequence
    sequence ack_done_s; ##1 !irq_acknowledge_cycle; endsequence
    ack_one_cycle_a: assert property (halt_ack_cycle |-> halted ##1 !halt_ack_cycle)
        else $error("halt ack not one halted cycle");
    ctrl_low_a: assert property (halted |-> !ctrl_out) else $error("control high while halted");
    stop_quiet_a: assert property (!clk_run |-> quiet_s) else $error("request while stopped");
    stop_guard_a: assert property ($fell(clk_run) |-> quiet_age_reg >= GUARD && ack_age_reg >= GUARD)
        else $error("clock stopped too early");
    wake_guard_a: assert property ($rose(clk_run) |-> quiet_s [*8]) else $error("request too soon after restart");
    stop_frozen_a: assert property (!clk_run && !$past(clk_run) |-> $stable(halted) && $stable(ctrl_out))
        else $error("outputs moved while stopped");
    hold_release_a: assert property (bus_hold_grant && !bus_hold_request |=> !bus_hold_grant && halted)
        else $error("no return to halt after hold");
    nmi_wake_a: assert property (halted && nmi_req && clk_run && !bus_hold_grant |=> !halted)
        else $error("nmi did not wake");
    irq_ack_seq_a: assert property (irq_acknowledge_cycle |-> $past(halted) ##0 ack_done_s)
        else $error("bad acknowledge cycle");
    halt_ack_entry_a: assert property ($rose(halted) |-> halt_ack_cycle)
        else $error("halt entered without acknowledge cycle");
    wake_wait_a: assert property (clk_run && run_age_reg < GUARD |-> quiet_s)
        else $error("request inside restart guard");
endmodule : stby_link_chk

// >>> stby_pkg.sv
// types shared by both ends of the standby link
package stby_pkg;
    typedef enum logic [2:0] {
        STBY_RUN,
        STBY_HALT,
        STBY_HOLD,
        STBY_ACK,
        STBY_SVC
    } stby_cpu_state_t;
    typedef enum logic [2:0] {
        STBY_X_IDLE,
        STBY_X_PRE,
        STBY_X_WAIT,
        STBY_X_STOP,
        STBY_X_POST
    } stby_ext_state_t;
endpackage : stby_pkg
